/* common/lcd_consts.svh */
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH

// frame identifiers, first three bits after chip select falls
`define ID_READ          3'h6
`define ID_WRITE         3'h5
`define ID_CMD           3'h4

// serial field lengths, in bits, counted from zero
`define ID_LAST          4'h2
`define ADDR_LAST        4'h5
`define CMD_LAST         4'h8
`define NIB_LAST         2'h3

// display memory
`define MEM_WORDS        32
`define ADDR_W           6

// clock source encodings
`define SRC_CRYSTAL      2'h1
`define SRC_INTERNAL_OSC 2'h2
`define SRC_EXTERNAL_CLK 2'h3

// power-on settings
`define RST_CLK_SRC      2'h2
`define RST_RATE         3'h7
`define RST_COMMONS      2'h2
`define RST_PINS         4'h7

// watchdog time-out, in time base periods
`define WDT_TB_PERIODS   3'h4

`endif

/* common/lcd_pkg.sv */
`include "lcd_consts.svh"

package lcd_pkg;

  typedef enum logic [2:0] {
    S_ID   = 3'h0,
    S_ADDR = 3'h1,
    S_DATA = 3'h3,
    S_CMD  = 3'h2,
    S_HALT = 3'h6
  } state_t;

  typedef struct packed {
    state_t                           st;
    logic [3:0]                       cnt;
    logic                             mode_read;
    logic [8:0]                       sh;
    logic [`ADDR_W-1:0]               addr;
    logic [3:0]                       wnib;
    logic [1:0]                       wcnt;
    logic [1:0]                       rcnt;
    logic                             wr_q;
    logic                             rd_q;
    logic                             dout;
    logic                             oe_n;
    logic                             osc_run;
    logic                             bias_on;
    logic                             buzzer_on;
    logic                             buzzer_low_freq;
    logic [1:0]                       clk_src;
    logic                             bias_third;
    logic [1:0]                       commons;
    logic [2:0]                       rate;
    logic                             tb_out_en;
    logic                             wd_flag_en;
    logic                             alert_en;
    logic                             test_mode;
    logic                             tb_clr;
    logic                             wd_clr;
    logic [1:0][`ADDR_W-1:0]          bq_addr;
    logic [1:0][3:0]                  bq_data;
    logic [1:0]                       bq_cnt;
    logic                             bq_rd;
    logic                             bq_wr;
    logic                             bq_full;
    logic [`MEM_WORDS-1:0][3:0]       mem;
  } core_t;

endpackage

/* src/pin_sync.sv */
`timescale 1ns/1ns

module pin_sync #(
  parameter int         W     = 4,
  parameter logic [3:0] RST_V = 4'h0
) (
  input  wire logic         CLK_SYS,
  input  wire logic         RESET,
  input  wire logic [W-1:0] PIN,
  output logic      [W-1:0] LEVEL
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // a level is taken only once two later stages agree, which also rejects single-sample glitches
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      s1    <= RST_V[W-1:0];
      s2    <= RST_V[W-1:0];
      s3    <= RST_V[W-1:0];
      LEVEL <= RST_V[W-1:0];
    end else begin
      s1 <= PIN;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          LEVEL[i] <= s3[i];
        end
      end
    end
  end

endmodule

/* src/lcd_serial_command_decoder.sv */
`timescale 1ns/1ns
`include "lcd_consts.svh"
// Behaviour
// - read frame: id 110, six address bits msb first, four data bits out lsb first
// - write frame: id 101, six address bits, four data bits lsb first stored
// - nibble_update_access uses id 101: nibble read out, then new nibble written there
// - code 0000-0000 stops oscillator and bias; 0000-0001 starts oscillator
// - code 0000-0010 turns bias off, 0000-0011 turns bias on
// - code 0000-0100 disables time base output, 0000-0110 enables it
// - code 0000-0101 disables watchdog flag output, 0000-0111 enables it
// - code 0000-1000 turns buzzer off, 0000-1001 turns buzzer on
// - any code 0000-11xx clears the time base counter
// - any code 0000-111x clears the watchdog stage
// - codes 0001-01/10/11 select crystal, internal oscillator or external clock
// - code 0010-abxc: c picks half or third bias, ab picks 2/3/4 commons
// - 010x gives 4 kHz buzzer, 011x gives 2 kHz, from selected source
// - code 101x-xfff picks time base 1 Hz to 128 Hz, doubling per step
// - watchdog times out after four time base periods
// - 1110-0000 enters test mode, 1110-0011 returns to normal
// - after command id, further commands follow without repeating the id
// - reset: oscillator off, bias off, buzzer off, internal source, alert off, 128 Hz, normal
// - chip select high aborts the operation; a fresh id is needed afterwards
// - bits on the data line are taken on each write strobe rising edge
// - each read bit is driven onto the data line on read strobe falling edge
// - alert enable connects time base or watchdog flag to alert pin, else floats

module lcd_serial_command_decoder
  import lcd_pkg::*;
(
  input  wire logic         CLK_SYS,
  input  wire logic         RESET,
  input  wire logic         CS_N,
  input  wire logic         WR_N,
  input  wire logic         RD_N,
  input  wire logic         DATA_IN,
  input  wire logic         DISPLAY_HOLD,
  output logic              DATA_OUT,
  output logic              DATA_OE_N,
  output logic              WRITE_BUSY,
  output logic              OSC_RUN,
  output logic              BIAS_ON,
  output logic              BUZZER_ON,
  output logic              BUZZER_LOW_FREQ,
  output logic [1:0]        CLK_SRC,
  output logic              BIAS_THIRD,
  output logic [1:0]        COMMONS,
  output logic [2:0]        RATE_SEL,
  output logic [2:0]        WATCHDOG_PERIODS,
  output logic              TIMEBASE_OUT_EN,
  output logic              WATCHDOG_FLAG_EN,
  output logic              ALERT_EN,
  output logic              TEST_MODE,
  output logic              TIME_BASE_CLEAR,
  output logic              WATCHDOG_CLEAR,
  output logic [127:0]      DISPLAY_MEM
);

  localparam core_t CORE_RESET = '{
    st:        S_ID,
    clk_src:   `RST_CLK_SRC,
    rate:      `RST_RATE,
    commons:   `RST_COMMONS,
    wr_q:      1'b1,
    rd_q:      1'b1,
    oe_n:      1'b1,
    default:   '0
  };

  core_t      r;
  core_t      next_r;
  logic [3:0] sy;
  logic       cs_high;
  logic       wr_rise;
  logic       rd_fall;
  logic       din;
  logic [8:0] cmd_word;
  logic [7:0] code;
  logic       cmd_done;
  logic       pop;
  logic       push;
  logic       rd_bit;

  // pins arrive from the host's clock world; data is synchronised alongside its strobes to stay aligned
  pin_sync #(
    .W     (4),
    .RST_V (`RST_PINS)
  ) u_sync (
    .CLK_SYS (CLK_SYS),
    .RESET   (RESET),
    .PIN     ({DATA_IN, RD_N, WR_N, CS_N}),
    .LEVEL   (sy)
  );

  assign cs_high  = sy[0];
  assign wr_rise  = sy[1] & ~r.wr_q;
  assign rd_fall  = ~sy[2] & r.rd_q;
  assign din      = sy[3];
  assign cmd_word = {r.sh[7:0], din};
  assign code     = cmd_word[8:1];
  assign cmd_done = !cs_high && r.st == S_CMD && wr_rise && r.cnt == `CMD_LAST;
  assign pop      = r.bq_cnt != 2'h0 && !DISPLAY_HOLD;

  // addresses beyond the memory read as zero and drop on write
  always_comb begin
    rd_bit = 1'b0;
    if (r.addr < `ADDR_W'(`MEM_WORDS)) begin
      rd_bit = r.mem[r.addr[4:0]][r.rcnt];
    end
  end

  always_comb begin
    next_r        = r;
    push          = 1'b0;
    next_r.tb_clr = 1'b0;
    next_r.wd_clr = 1'b0;
    next_r.wr_q   = sy[1];
    next_r.rd_q   = sy[2];

    // buffer drain into the memory; display logic may hold it off
    if (pop) begin
      if (r.bq_addr[r.bq_rd] < `ADDR_W'(`MEM_WORDS)) begin
        next_r.mem[r.bq_addr[r.bq_rd][4:0]] = r.bq_data[r.bq_rd];
      end
      next_r.bq_rd = ~r.bq_rd;
    end

    if (cs_high) begin
      next_r.st   = S_ID;
      next_r.cnt  = 4'h0;
      next_r.wcnt = 2'h0;
      next_r.rcnt = 2'h0;
      next_r.oe_n = 1'b1;
    end else begin
      case (r.st)
        S_ID: begin
          if (wr_rise) begin
            next_r.sh  = cmd_word;
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == `ID_LAST) begin
              next_r.cnt = 4'h0;
              case (cmd_word[2:0])
                `ID_READ: begin
                  next_r.st        = S_ADDR;
                  next_r.mode_read = 1'b1;
                end
                `ID_WRITE: begin
                  next_r.st        = S_ADDR;
                  next_r.mode_read = 1'b0;
                end
                `ID_CMD: begin
                  next_r.st = S_CMD;
                end
                default: begin
                  next_r.st = S_HALT;
                end
              endcase
            end
          end
        end
        S_ADDR: begin
          if (wr_rise) begin
            next_r.sh  = cmd_word;
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == `ADDR_LAST) begin
              next_r.addr = cmd_word[`ADDR_W-1:0];
              next_r.cnt  = 4'h0;
              next_r.wcnt = 2'h0;
              next_r.rcnt = 2'h0;
              next_r.st   = S_DATA;
            end
          end
        end
        S_DATA: begin
          // read side also serves the read half of a nibble_update_access
          if (rd_fall) begin
            next_r.oe_n = 1'b0;
            next_r.dout = rd_bit;
            next_r.rcnt = r.rcnt + 2'h1;
            if (r.rcnt == `NIB_LAST && r.mode_read) begin
              next_r.addr = r.addr + `ADDR_W'(1);
            end
          end
          if (wr_rise && !r.mode_read) begin
            next_r.oe_n          = 1'b1;
            next_r.wnib[r.wcnt]  = din;
            next_r.wcnt          = r.wcnt + 2'h1;
            if (r.wcnt == `NIB_LAST) begin
              // a full buffer drops the nibble; the host watches WRITE_BUSY to avoid that
              push        = !r.bq_full;
              next_r.addr = r.addr + `ADDR_W'(1);
              next_r.rcnt = 2'h0;
            end
          end
        end
        S_CMD: begin
          if (wr_rise) begin
            next_r.sh  = cmd_word;
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == `CMD_LAST) begin
              next_r.cnt = 4'h0;
            end
          end
        end
        S_HALT: begin
          next_r.oe_n = 1'b1;
        end
        default: begin
          next_r.st = S_ID;
        end
      endcase
    end

    if (push) begin
      next_r.bq_addr[r.bq_wr] = r.addr;
      next_r.bq_data[r.bq_wr] = {din, r.wnib[2:0]};
      next_r.bq_wr            = ~r.bq_wr;
    end
    next_r.bq_cnt  = r.bq_cnt + {1'b0, push} - {1'b0, pop};
    next_r.bq_full = next_r.bq_cnt == 2'h2;

    if (cmd_done) begin
      if (code[7:2] == 6'h03) begin
        next_r.tb_clr = 1'b1;
      end
      if (code[7:1] == 7'h07) begin
        next_r.wd_clr = 1'b1;
      end
      casez (code)
        8'b0000_0000: begin
          next_r.osc_run = 1'b0;
          next_r.bias_on = 1'b0;
        end
        8'b0000_0001: next_r.osc_run = 1'b1;
        8'b0000_0010: next_r.bias_on = 1'b0;
        8'b0000_0011: next_r.bias_on = 1'b1;
        8'b0000_0100: next_r.tb_out_en = 1'b0;
        8'b0000_0101: next_r.wd_flag_en = 1'b0;
        8'b0000_0110: begin
          next_r.tb_out_en  = 1'b1;
          next_r.wd_flag_en = 1'b0;
        end
        8'b0000_0111: begin
          next_r.wd_flag_en = 1'b1;
          next_r.tb_out_en  = 1'b0;
        end
        8'b0000_1000: next_r.buzzer_on = 1'b0;
        8'b0000_1001: next_r.buzzer_on = 1'b1;
        8'b0001_01??, 8'b0001_10??, 8'b0001_11??: begin
          next_r.clk_src = code[3:2];
        end
        8'b0010_????: begin
          next_r.bias_third = code[0];
          if (code[3:2] != 2'h3) begin
            next_r.commons = code[3:2];
          end
        end
        // tone is divided from whichever source CLK_SRC names
        8'b010?_????: next_r.buzzer_low_freq = 1'b0;
        8'b011?_????: next_r.buzzer_low_freq = 1'b1;
        8'b100?_0???: next_r.alert_en = 1'b0;
        8'b100?_1???: next_r.alert_en = 1'b1;
        8'b101?_????: next_r.rate = code[2:0];
        8'b1110_0000: next_r.test_mode = 1'b1;
        8'b1110_0011: next_r.test_mode = 1'b0;
        default: begin
          next_r.test_mode = r.test_mode;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      r <= CORE_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign DATA_OUT         = r.dout;
  assign DATA_OE_N        = r.oe_n;
  assign WRITE_BUSY       = r.bq_full;
  assign OSC_RUN          = r.osc_run;
  assign BIAS_ON          = r.bias_on;
  assign BUZZER_ON        = r.buzzer_on;
  assign BUZZER_LOW_FREQ  = r.buzzer_low_freq;
  assign CLK_SRC          = r.clk_src;
  assign BIAS_THIRD       = r.bias_third;
  assign COMMONS          = r.commons;
  assign RATE_SEL         = r.rate;
  assign TIMEBASE_OUT_EN  = r.tb_out_en;
  assign WATCHDOG_FLAG_EN = r.wd_flag_en;
  assign ALERT_EN         = r.alert_en;
  assign TEST_MODE        = r.test_mode;
  assign TIME_BASE_CLEAR  = r.tb_clr;
  assign WATCHDOG_CLEAR   = r.wd_clr;
  assign DISPLAY_MEM      = r.mem;

  // constant: the watchdog counts time base periods, so its time-out tracks RATE_SEL
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      WATCHDOG_PERIODS <= `WDT_TB_PERIODS;
    end else begin
      WATCHDOG_PERIODS <= `WDT_TB_PERIODS;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  property p_cs_abort;
    cs_high |=> r.st == S_ID && r.cnt == 4'h0 && DATA_OE_N;
  endproperty
  a_cs_abort: assert property (p_cs_abort) else $error("chip select high did not abort frame");

  property p_system_disable;
    cmd_done && code == 8'h00 |=> !OSC_RUN && !BIAS_ON;
  endproperty
  a_system_disable: assert property (p_system_disable) else $error("system disable left oscillator or bias on");

  property p_bias_on;
    cmd_done && code == 8'h03 |=> BIAS_ON ##1 BIAS_ON || $past(cmd_done);
  endproperty
  a_bias_on: assert property (p_bias_on) else $error("bias enable did not take");

  property p_tb_clear;
    cmd_done && code[7:2] == 6'h03 |=> TIME_BASE_CLEAR ##1 !TIME_BASE_CLEAR;
  endproperty
  a_tb_clear: assert property (p_tb_clear) else $error("time base clear pulse wrong");

  property p_wd_clear;
    WATCHDOG_CLEAR |-> $past(cmd_done) && $past(code[7:1]) == 7'h07;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog clear without its command");

  property p_clk_src;
    cmd_done && code[7:4] == 4'h1 && code[3:2] != 2'h0 |=> CLK_SRC == $past(code[3:2]);
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("clock source not taken from command");

  property p_rate;
    cmd_done && code[7:5] == 3'h5 |=> RATE_SEL == $past(code[2:0]);
  endproperty
  a_rate: assert property (p_rate) else $error("time base rate not taken from command");

  property p_rd_drive;
    !cs_high && r.st == S_DATA && rd_fall |=> !DATA_OE_N && DATA_OUT == $past(rd_bit);
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read bit not driven after strobe fall");

  property p_cmd_stays;
    cmd_done && !$past(cs_high) |=> r.st == S_CMD && r.cnt == 4'h0;
  endproperty
  a_cmd_stays: assert property (p_cmd_stays) else $error("command mode left after a command");

endmodule

/* test/host_model.sv */
`timescale 1ns/1ns

// host end of the serial link; chip select, strobes and host-driven data move on the falling clock edge
module host_model (
  input  wire logic clk,
  input  wire logic dout,
  input  wire logic oe_n,
  output logic      cs_n,
  output logic      wr_n,
  output logic      rd_n,
  output logic      din
);
  logic hbit = 1'b0;
  logic hen  = 1'b0;
  logic last = 1'b0;

  // no pull on the line: released, it toggles; host drive wins at turn-around
  assign din = hen ? hbit : (!oe_n ? dout : ~last);
  always @(posedge clk) last <= din;
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // msb first, each bit held across the strobe's rising edge
  task automatic send(input logic [8:0] v, input int n);
    // the strobe leaves its idle high level and returns to it for every bit
    for (int i = n - 1; i >= 0; i--) begin
      wr_n = ~wr_n;
      hbit = v[i];
      hen  = 1'b1;
      tick(4);
      wr_n = ~wr_n;
      tick(4);
    end
  endtask

  task automatic open_frame(input logic [2:0] id);
    cs_n = 1'b0;
    tick(5);
    send({6'h0, id}, 3);
  endtask

  task automatic close_frame();
    cs_n = 1'b1;
    hen  = 1'b0;
    tick(6);
  endtask

  task automatic send_nib(input logic [3:0] d);
    send({5'h0, d[0], d[1], d[2], d[3]}, 4);
  endtask

  task automatic read_nib(output logic [3:0] d);
    hen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_n = ~rd_n;
      tick(4);
      rd_n = ~rd_n;
      tick(3);
      d[i] = din;
      tick(1);
    end
  endtask
endmodule

/* test/lcd_serial_command_decoder_tb_top.sv */
`timescale 1ns/1ns
`include "lcd_consts.svh"

module lcd_serial_command_decoder_tb_top;
  logic         clk;
  logic         reset;
  logic         hold;
  logic         cs_n, wr_n, rd_n, din, dout, oe_n, busy;
  logic         osc, bias, buzz, low, third, tben, wden, alert, test, tbclr, wdclr;
  logic [1:0]   src, commons;
  logic [2:0]   rate, wdp;
  logic [127:0] mem, mem_exp;
  logic [15:0]  cfg, cfg_exp;
  logic [3:0]   nib;
  logic [3:0]   nibs [3];
  logic [5:0]   a, a0;
  logic [31:0]  r;
  integer       seed;
  int           fail_count  = 0;
  int           check_count = 0;
  int           tb_cnt = 0, wd_cnt = 0, tb_exp = 0, wd_exp = 0;
  logic [7:0]   codes [0:29] = '{8'h01, 8'h03, 8'h09, 8'h05, 8'h07, 8'h04, 8'h06, 8'h0c, 8'h0e, 8'h08,
                                 8'h02, 8'h00, 8'h14, 8'h1c, 8'h18, 8'h29, 8'h24, 8'h20, 8'h2f, 8'h40,
                                 8'h60, 8'h88, 8'h80, 8'ha0, 8'ha7, 8'he0, 8'he3, 8'h01, 8'h03, 8'h0f};

  assign cfg = {osc, bias, buzz, low, src, third, commons, rate, tben, wden, alert, test};

  lcd_serial_command_decoder lcd_serial_command_decoder_inst (
    .CLK_SYS          (clk),
    .RESET            (reset),
    .CS_N             (cs_n),
    .WR_N             (wr_n),
    .RD_N             (rd_n),
    .DATA_IN          (din),
    .DISPLAY_HOLD     (hold),
    .DATA_OUT         (dout),
    .DATA_OE_N        (oe_n),
    .WRITE_BUSY       (busy),
    .OSC_RUN          (osc),
    .BIAS_ON          (bias),
    .BUZZER_ON        (buzz),
    .BUZZER_LOW_FREQ  (low),
    .CLK_SRC          (src),
    .BIAS_THIRD       (third),
    .COMMONS          (commons),
    .RATE_SEL         (rate),
    .WATCHDOG_PERIODS (wdp),
    .TIMEBASE_OUT_EN  (tben),
    .WATCHDOG_FLAG_EN (wden),
    .ALERT_EN         (alert),
    .TEST_MODE        (test),
    .TIME_BASE_CLEAR  (tbclr),
    .WATCHDOG_CLEAR   (wdclr),
    .DISPLAY_MEM      (mem)
  );

  host_model host_model_inst (
    .clk  (clk),
    .dout (dout),
    .oe_n (oe_n),
    .cs_n (cs_n),
    .wr_n (wr_n),
    .rd_n (rd_n),
    .din  (din)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // clear pulses last one cycle, so they are counted rather than caught
  always @(posedge clk) begin
    tb_cnt <= tb_cnt + int'(tbclr === 1'b1);
    wd_cnt <= wd_cnt + int'(wdclr === 1'b1);
  end

  task automatic final_report();
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    final_report();
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] want);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // cfg bits: osc bias buzz low src[2] third commons[2] rate[3] tben wden alert test
  function automatic logic [15:0] next_cfg(input logic [15:0] c, input logic [7:0] b);
    case (b) inside
      8'h00:                    c[15:14] = 2'b00;
      8'h01:                    c[15] = 1'b1;
      8'h02, 8'h03:             c[14] = b[0];
      8'h04:                    c[3] = 1'b0;
      8'h05:                    c[2] = 1'b0;
      8'h06, 8'h07:             c[3:2] = {~b[0], b[0]};
      8'h08, 8'h09:             c[13] = b[0];
      8'b0001_01??, 8'b0001_1???: c[11:10] = b[3:2];
      8'b0010_0???, 8'b0010_10??: c[9:7] = {b[0], b[3:2]};
      // commons code 11 is refused, the bias bit still takes
      8'b0010_11??:             c[9] = b[0];
      8'b01??_????:             c[12] = b[5];
      8'b100?_????:             c[1] = b[3];
      8'b101?_????:             c[6:4] = b[2:0];
      8'he0, 8'he3:             c[0] = ~b[0];
      default:                  c = c;
    endcase
    return c;
  endfunction

  function automatic logic [3:0] nib_at(input int i);
    return (i < `MEM_WORDS) ? mem_exp[i*4 +: 4] : 4'h0;
  endfunction

  task automatic send_cmd(input logic [7:0] b);
    r = $random(seed);
    host_model_inst.send({b, r[0]}, 9);
    host_model_inst.tick(4);
    cfg_exp = next_cfg(cfg_exp, b);
    tb_exp += int'(b[7:2] == 6'h03);
    wd_exp += int'(b[7:1] == 7'h07);
    check(cfg, cfg_exp);
    check(tb_cnt, tb_exp);
    check(wd_cnt, wd_exp);
  endtask

  task automatic write_nib(input int i, input logic [3:0] d);
    host_model_inst.send_nib(d);
    if (i < `MEM_WORDS) mem_exp[i*4 +: 4] = d;
  endtask

  task automatic read_run(input logic [5:0] ra, input int n);
    host_model_inst.open_frame(3'h6);
    host_model_inst.send({3'h0, ra}, 6);
    for (int k = 0; k < n; k++) begin
      host_model_inst.read_nib(nib);
      check(nib, nib_at(ra + k));
    end
    check(oe_n, 1'b0);
    host_model_inst.close_frame();
    check(oe_n, 1'b1);
  endtask

  initial begin
    seed = 32'h6c61;
    reset = 1'b1;
    hold = 1'b0;
    mem_exp = '0;
    cfg_exp = {4'h0, `RST_CLK_SRC, 1'b0, `RST_COMMONS, `RST_RATE, 4'h0};
    repeat (3) @(negedge clk);
    reset = 1'b0;
    check(cfg, cfg_exp);
    check({oe_n, wdp}, {1'b1, `WDT_TB_PERIODS});
    check(mem, 128'h0);
    host_model_inst.tick(5);
    // whole set written once after power-on, then random codes, all in one frame
    host_model_inst.open_frame(3'h4);
    for (int i = 0; i < 30; i++) send_cmd(codes[i]);
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      send_cmd(r[7:0]);
    end
    send_cmd(8'h03);
    host_model_inst.close_frame();
    // command bits behind an unknown identifier must be ignored
    host_model_inst.open_frame(3'h0);
    host_model_inst.send(9'h004, 9);
    host_model_inst.close_frame();
    check(cfg, cfg_exp);
    r = $random(seed);
    a0 = {1'b0, r[4:0]};
    host_model_inst.open_frame(3'h5);
    host_model_inst.send({3'h0, a0}, 6);
    for (int k = 0; k < 3; k++) begin
      r = $random(seed);
      write_nib(a0 + k, r[3:0]);
    end
    host_model_inst.close_frame();
    check(mem, mem_exp);
    // stalled drain: two nibbles fill the buffer, the third is refused
    hold = 1'b1;
    r = $random(seed);
    a = {1'b0, r[4:0]};
    host_model_inst.open_frame(3'h5);
    host_model_inst.send({3'h0, a}, 6);
    for (int k = 0; k < 3; k++) begin
      r = $random(seed);
      nibs[k] = r[3:0];
      host_model_inst.send_nib(nibs[k]);
    end
    check(busy, 1'b1);
    check(mem, mem_exp);
    hold = 1'b0;
    host_model_inst.close_frame();
    for (int k = 0; k < 2; k++) if (a + k < `MEM_WORDS) mem_exp[(a + k)*4 +: 4] = nibs[k];
    check(busy, 1'b0);
    check(mem, mem_exp);
    read_run(a0, 3);
    read_run(6'h1f, 2);
    // two successive read-then-write steps on the same identifier; the drain may be held meanwhile
    r = $random(seed);
    hold = r[0];
    host_model_inst.open_frame(3'h5);
    host_model_inst.send({3'h0, a0}, 6);
    for (int k = 0; k < 2; k++) begin
      host_model_inst.read_nib(nib);
      check(nib, nib_at(a0 + k));
      r = $random(seed);
      write_nib(a0 + k, r[3:0]);
    end
    hold = 1'b0;
    host_model_inst.close_frame();
    check(mem, mem_exp);
    // a partial nibble cut off by chip select is lost
    host_model_inst.open_frame(3'h5);
    host_model_inst.send({3'h0, a0}, 6);
    host_model_inst.send(9'h1ff, 2);
    host_model_inst.close_frame();
    check(mem, mem_exp);
    final_report();
  end
endmodule
